// ### rtl/tst_pkg.sv
// Package: constants, TAP states and state records for the scan port
package tst_pkg;

  // ==========================================================
  // Widths and depths
  localparam int IR_W   = 8;  // Instruction register width
  localparam int DR_W   = 8;  // User data register width
  localparam int FIFO_D = 16; // Words buffered toward the system side

  // ==========================================================
  // Capture, decode and reset values
  localparam logic [7:0] IR_CAPTURE = 8'h81; // Fixed pattern loaded at Capture-IR
  localparam logic [7:0] IR_BYPASS  = 8'hff; // All ones selects bypass
  localparam logic [7:0] DR_RESET   = 8'h00; // Parallel stage after reset

  // ==========================================================
  // TAP controller states, one-hot
  typedef enum logic [15:0] {
    S_TLR    = 16'h0001,
    S_IDLE   = 16'h0002,
    S_SEL_DR = 16'h0004,
    S_CAP_DR = 16'h0008,
    S_SH_DR  = 16'h0010,
    S_EX1_DR = 16'h0020,
    S_PAU_DR = 16'h0040,
    S_EX2_DR = 16'h0080,
    S_UPD_DR = 16'h0100,
    S_SEL_IR = 16'h0200,
    S_CAP_IR = 16'h0400,
    S_SH_IR  = 16'h0800,
    S_EX1_IR = 16'h1000,
    S_PAU_IR = 16'h2000,
    S_EX2_IR = 16'h4000,
    S_UPD_IR = 16'h8000
  } tst_state_t;

  // ==========================================================
  // State updated on the rising test clock edge
  typedef struct packed {
    logic             rst_s1; // Reset synchroniser, first stage
    logic             rst_q;  // Reset synchroniser, second stage (low = reset)
    tst_state_t       state;  // TAP controller state
    logic [IR_W-1:0]  ir_sh;  // Instruction shift stage
    logic [DR_W-1:0]  dr_sh;  // User data shift stage
    logic             byp;    // Bypass stage
  } tst_rise_t;

  // State updated on the falling test clock edge
  typedef struct packed {
    logic             tdo;      // Serial output
    logic             tdo_oe_n; // Serial output enable, low drives
    logic [IR_W-1:0]  ir;       // Active instruction latch
    logic [DR_W-1:0]  dr_par;   // Parallel stage of the user register
    logic             upd_tog;  // Flips on each user register update
  } tst_fall_t;

  // System clock side of the update crossing
  typedef struct packed {
    logic             s1;      // Toggle synchroniser, first stage
    logic             s2;      // Toggle synchroniser, second stage
    logic             s3;      // Delayed copy for edge detection
    logic [DR_W-1:0]  word;    // Word waiting for the FIFO
    logic             pend;    // Word held and not yet pushed
    logic             overrun; // Update lost while the FIFO stalled
  } tst_sys_t;

endpackage : tst_pkg

// ### rtl/tst_top.sv
// Test access port with scan timing, update crossing and buffer
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Buffer between the update crossing and the user side
module tst_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  // Filling side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // Draining side
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(D);

  // All FIFO state; one extra pointer bit tells full from empty
  typedef struct packed {
    logic [D-1:0][W-1:0] mem; // Storage words
    logic [AW:0]         wp;  // Write pointer
    logic [AW:0]         rp;  // Read pointer
  } tst_fifo_t;

  tst_fifo_t q;      // Registered state
  tst_fifo_t next_q; // Next state
  logic      full;   // No room left
  logic      empty;  // Nothing stored
  logic      push;   // Word accepted
  logic      pop;    // Word delivered

  assign full        = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
  assign empty       = (q.wp == q.rp);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = q.mem[q.rp[AW-1:0]];
  assign push        = in_valid_i && !full;
  assign pop         = out_valid_o && out_ready_i;

  // Pointer and storage update
  always_comb begin
    next_q = q;
    if (push) begin
      next_q.mem[q.wp[AW-1:0]] = in_data_i;
      next_q.wp                = q.wp + 1'b1;
    end
    if (pop) begin
      next_q.rp = q.rp + 1'b1;
    end
    if (!resetn_i) begin
      next_q.wp = '0;
      next_q.rp = '0;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    q <= next_q;
  end
endmodule : tst_fifo

// ==========================================================
// Top: TAP on the test clock, buffered updates on the system clock
module tst_top (
  // System clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     resetn_i,
  // Test port from the external controller
  input  wire logic                     tck_i,
  input  wire logic                     tms_i,
  input  wire logic                     tdi_i,
  output logic                          tdo_o,
  output logic                          tdo_oe_n_o,
  // Normal-function pins seen and driven by test logic
  input  wire logic [tst_pkg::DR_W-1:0] pin_in_i,
  output logic [tst_pkg::DR_W-1:0]      test_out_o,
  output logic [tst_pkg::IR_W-1:0]      instr_o,
  // Updated words toward the system
  output logic                          rx_valid_o,
  output logic [tst_pkg::DR_W-1:0]      rx_data_o,
  input  wire logic                     rx_ready_i,
  output logic                          overrun_o
);

  // ==========================================================
  // State records
  tst_pkg::tst_rise_t r;      // Rising edge state
  tst_pkg::tst_rise_t next_r; // Its next value
  tst_pkg::tst_fall_t f;      // Falling edge state
  tst_pkg::tst_fall_t next_f; // Its next value
  tst_pkg::tst_sys_t  s;      // System side state
  tst_pkg::tst_sys_t  next_s; // Its next value
  logic               bypass; // Bypass instruction active
  logic               evt;    // Update seen on the system side
  logic               fifo_rdy; // Buffer can take a word
  logic               push;   // Held word goes into the buffer

  // ==========================================================
  // TAP transition graph
  function automatic tst_pkg::tst_state_t tap_next(
    input tst_pkg::tst_state_t st,
    input logic                tms
  );
    tst_pkg::tst_state_t nx;
    nx = tst_pkg::S_TLR;
    case (st)
      tst_pkg::S_TLR:    nx = tms ? tst_pkg::S_TLR    : tst_pkg::S_IDLE;
      tst_pkg::S_IDLE:   nx = tms ? tst_pkg::S_SEL_DR : tst_pkg::S_IDLE;
      tst_pkg::S_SEL_DR: nx = tms ? tst_pkg::S_SEL_IR : tst_pkg::S_CAP_DR;
      tst_pkg::S_CAP_DR: nx = tms ? tst_pkg::S_EX1_DR : tst_pkg::S_SH_DR;
      tst_pkg::S_SH_DR:  nx = tms ? tst_pkg::S_EX1_DR : tst_pkg::S_SH_DR;
      tst_pkg::S_EX1_DR: nx = tms ? tst_pkg::S_UPD_DR : tst_pkg::S_PAU_DR;
      tst_pkg::S_PAU_DR: nx = tms ? tst_pkg::S_EX2_DR : tst_pkg::S_PAU_DR;
      tst_pkg::S_EX2_DR: nx = tms ? tst_pkg::S_UPD_DR : tst_pkg::S_SH_DR;
      tst_pkg::S_UPD_DR: nx = tms ? tst_pkg::S_SEL_DR : tst_pkg::S_IDLE;
      tst_pkg::S_SEL_IR: nx = tms ? tst_pkg::S_TLR    : tst_pkg::S_CAP_IR;
      tst_pkg::S_CAP_IR: nx = tms ? tst_pkg::S_EX1_IR : tst_pkg::S_SH_IR;
      tst_pkg::S_SH_IR:  nx = tms ? tst_pkg::S_EX1_IR : tst_pkg::S_SH_IR;
      tst_pkg::S_EX1_IR: nx = tms ? tst_pkg::S_UPD_IR : tst_pkg::S_PAU_IR;
      tst_pkg::S_PAU_IR: nx = tms ? tst_pkg::S_EX2_IR : tst_pkg::S_PAU_IR;
      tst_pkg::S_EX2_IR: nx = tms ? tst_pkg::S_UPD_IR : tst_pkg::S_SH_IR;
      tst_pkg::S_UPD_IR: nx = tms ? tst_pkg::S_SEL_DR : tst_pkg::S_IDLE;
      // Illegal code falls back to reset
      default:           nx = tst_pkg::S_TLR;
    endcase
    return nx;
  endfunction : tap_next

  // ==========================================================
  // Rising edge: state, capture and shift
  assign bypass = (f.ir == tst_pkg::IR_BYPASS);

  // Controller timing keeps TMS stable here, so no synchroniser on it
  always_comb begin
    next_r        = r;
    next_r.rst_s1 = resetn_i;
    next_r.rst_q  = r.rst_s1;
    if (!r.rst_q) begin
      next_r.state = tst_pkg::S_TLR;
      next_r.ir_sh = tst_pkg::IR_CAPTURE;
      next_r.dr_sh = tst_pkg::DR_RESET;
      next_r.byp   = 1'b0;
    end else begin
      // Five TMS highs reach reset from anywhere in the graph
      next_r.state = tap_next(r.state, tms_i);
      case (r.state)
        // Fixed capture pattern on leaving Capture-IR
        tst_pkg::S_CAP_IR: begin
          next_r.ir_sh = tst_pkg::IR_CAPTURE;
        end
        // Shift also runs on the edge that exits to Exit1
        tst_pkg::S_SH_IR: begin
          next_r.ir_sh = {tdi_i, r.ir_sh[tst_pkg::IR_W-1:1]};
        end
        // Bypass clears; user stage samples the pins
        tst_pkg::S_CAP_DR: begin
          next_r.byp   = 1'b0;
          next_r.dr_sh = pin_in_i;
        end
        tst_pkg::S_SH_DR: begin
          next_r.byp   = tdi_i;
          next_r.dr_sh = {tdi_i, r.dr_sh[tst_pkg::DR_W-1:1]};
        end
        // Other states hold the shift stages
        default: begin
        end
      endcase
    end
  end

  // Rising edge register; nothing here sees the system clock
  always_ff @(posedge tck_i) begin
    r <= next_r;
  end

  // ==========================================================
  // Falling edge: serial output, enable and update latches
  always_comb begin
    next_f = f;
    if (!r.rst_q) begin
      next_f.tdo      = 1'b0;
      next_f.tdo_oe_n = 1'b1;
      next_f.ir       = tst_pkg::IR_BYPASS;
      next_f.dr_par   = tst_pkg::DR_RESET;
      next_f.upd_tog  = 1'b0;
    end else begin
      // Driven only in shift states, floated in Exit1 and elsewhere
      next_f.tdo_oe_n = !(r.state == tst_pkg::S_SH_IR ||
                          r.state == tst_pkg::S_SH_DR);
      if (r.state == tst_pkg::S_SH_IR) begin
        next_f.tdo = r.ir_sh[0];
      end else if (r.state == tst_pkg::S_SH_DR) begin
        next_f.tdo = bypass ? r.byp : r.dr_sh[0];
      end
      // Reset state selects bypass
      if (r.state == tst_pkg::S_TLR) begin
        next_f.ir = tst_pkg::IR_BYPASS;
      end
      if (r.state == tst_pkg::S_UPD_IR) begin
        next_f.ir = r.ir_sh;
      end
      // Bypass has no parallel stage, so no update is posted
      if (r.state == tst_pkg::S_UPD_DR && !bypass) begin
        next_f.dr_par  = r.dr_sh;
        next_f.upd_tog = !f.upd_tog;
      end
    end
  end

  // Falling edge register drives every test output
  always_ff @(negedge tck_i) begin
    f <= next_f;
  end

  assign tdo_o      = f.tdo;
  assign tdo_oe_n_o = f.tdo_oe_n;
  assign test_out_o = f.dr_par;
  assign instr_o    = f.ir;

  // ==========================================================
  // System side: toggle crossing, hold word, push to buffer
  // The word is stable long before the toggle is seen here
  assign evt  = s.s2 ^ s.s3;
  assign push = s.pend && fifo_rdy;

  always_comb begin
    next_s         = s;
    next_s.s1      = f.upd_tog;
    next_s.s2      = s.s1;
    next_s.s3      = s.s2;
    next_s.overrun = 1'b0;
    if (push) begin
      next_s.pend = 1'b0;
    end
    // A new word wins over the push that frees the holder
    if (evt) begin
      if (s.pend && !push) begin
        // Buffer stalled; the scan port cannot be held off
        next_s.overrun = 1'b1;
      end else begin
        next_s.word = f.dr_par;
        next_s.pend = 1'b1;
      end
    end
    if (!resetn_i) begin
      next_s.s1      = 1'b0;
      next_s.s2      = 1'b0;
      next_s.s3      = 1'b0;
      next_s.word    = tst_pkg::DR_RESET;
      next_s.pend    = 1'b0;
      next_s.overrun = 1'b0;
    end
  end

  // System side register
  always_ff @(posedge clk_i) begin
    s <= next_s;
  end

  assign overrun_o = s.overrun;

  // Buffer toward the user
  tst_fifo #(
    .W (tst_pkg::DR_W),
    .D (tst_pkg::FIFO_D)
  ) u_fifo (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (s.pend),
    .in_data_i   (s.word),
    .in_ready_o  (fifo_rdy),
    .out_valid_o (rx_valid_o),
    .out_data_o  (rx_data_o),
    .out_ready_i (rx_ready_i)
  );

  // ==========================================================
  // Checks on the test clock
  property p_tlr_idle;
    @(posedge tck_i) disable iff (!r.rst_q)
    (r.state == tst_pkg::S_TLR && !tms_i) |=> (r.state == tst_pkg::S_IDLE);
  endproperty
  a_tlr_idle: assert property (p_tlr_idle)
    else $error("reset state did not move to idle");

  property p_cap_ir;
    @(posedge tck_i) disable iff (!r.rst_q)
    (r.state == tst_pkg::S_CAP_IR) |=> (r.ir_sh == tst_pkg::IR_CAPTURE);
  endproperty
  a_cap_ir: assert property (p_cap_ir)
    else $error("capture pattern missing");

  property p_sh_ir;
    @(posedge tck_i) disable iff (!r.rst_q)
    (r.state == tst_pkg::S_SH_IR && tms_i) |=>
      (r.state == tst_pkg::S_EX1_IR && r.ir_sh[7] == $past(tdi_i));
  endproperty
  a_sh_ir: assert property (p_sh_ir)
    else $error("last instruction bit not shifted");

  property p_five_tms;
    @(posedge tck_i) disable iff (!r.rst_q)
    tms_i [*5] |=> (r.state == tst_pkg::S_TLR);
  endproperty
  a_five_tms: assert property (p_five_tms)
    else $error("five TMS highs did not reset");

  property p_shift_oe;
    @(posedge tck_i) disable iff (!r.rst_q)
    ($past(r.rst_q) && (r.state == tst_pkg::S_SH_IR || r.state == tst_pkg::S_SH_DR))
      |-> !f.tdo_oe_n;
  endproperty
  a_shift_oe: assert property (p_shift_oe)
    else $error("TDO not driven in shift");

  property p_exit_hiz;
    @(posedge tck_i) disable iff (!r.rst_q)
    (r.state == tst_pkg::S_EX1_IR || r.state == tst_pkg::S_EX1_DR) |-> f.tdo_oe_n;
  endproperty
  a_exit_hiz: assert property (p_exit_hiz)
    else $error("TDO driven in exit state");

  property p_byp_cap;
    @(posedge tck_i) disable iff (!r.rst_q)
    (r.state == tst_pkg::S_CAP_DR) |=> !r.byp;
  endproperty
  a_byp_cap: assert property (p_byp_cap)
    else $error("bypass stage not cleared");

  property p_byp_lag;
    @(posedge tck_i) disable iff (!r.rst_q)
    (bypass && r.state == tst_pkg::S_SH_DR && $past(r.state) == tst_pkg::S_SH_DR)
      |-> (f.tdo == $past(tdi_i));
  endproperty
  a_byp_lag: assert property (p_byp_lag)
    else $error("bypass output not one shift behind");

  property p_upd_ir;
    @(posedge tck_i) disable iff (!r.rst_q)
    (r.state == tst_pkg::S_UPD_IR && $past(r.rst_q)) |-> (f.ir == r.ir_sh);
  endproperty
  a_upd_ir: assert property (p_upd_ir)
    else $error("instruction not latched");

  property p_upd_dr;
    @(posedge tck_i) disable iff (!r.rst_q)
    (r.state == tst_pkg::S_UPD_DR && !bypass && $past(r.rst_q)) |->
      (f.dr_par == r.dr_sh);
  endproperty
  a_upd_dr: assert property (p_upd_dr)
    else $error("parallel stage not updated");

endmodule : tst_top
`default_nettype wire

// ### tb/tst_ctl_model.sv
// Scan controller model that drives the test port one clock cycle at a time
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Controller: each call of step makes one test clock cycle
module tst_ctl_model (
  // Test port toward the device
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_n_i
);
  // Clock idles low and only runs inside a step, as a real probe may stop it
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // Mode and data change right after the falling edge, the device samples at rise
  task automatic step(input logic t, input logic d, output logic o, output logic oe_n);
    tms_o = t;
    tdi_o = d;
    #6;
    // Output stands from the previous fall, so look just before the rise
    // A floating line reads as the opposite level, so a missed enable shows as a bad bit
    o     = tdo_oe_n_i ? !tdo_i : tdo_i;
    oe_n  = tdo_oe_n_i;
    tck_o = 1'b1;
    #6;
    tck_o = 1'b0;
  endtask : step
endmodule : tst_ctl_model
`default_nettype wire

// ### tb/tst_top_test.sv
// Self-checking bench for the scan port, its update stream and buffer
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Top of the bench
module tst_top_test;
  logic       clk_i      = 1'b0; // System clock
  logic       resetn_i   = 1'b0; // System reset, low resets
  logic [7:0] pin_in_i   = 8'h00; // Normal-function inputs
  logic       rx_ready_i = 1'b0; // Consumer ready
  logic       drain      = 1'b1; // Consumer allowed to take words
  logic       tck, tms, tdi, tdo_o, tdo_oe_n_o, rx_valid_o, overrun_o;
  logic [7:0] test_out_o, instr_o, rx_data_o;
  logic [7:0] exp_q[$];          // Words expected at the consumer
  logic [7:0] got_q[$];          // Words taken by the consumer
  int         fail_count  = 0;
  int         comparisons = 0;
  int         ovr_n       = 0;   // Overrun pulses seen

  // Clock toggles every half period
  always #4 clk_i = ~clk_i;

  tst_ctl_model ctl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_o),
                     .tdo_oe_n_i(tdo_oe_n_o));

  tst_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
               .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o), .pin_in_i(pin_in_i),
               .test_out_o(test_out_o), .instr_o(instr_o), .rx_valid_o(rx_valid_o),
               .rx_data_o(rx_data_o), .rx_ready_i(rx_ready_i), .overrun_o(overrun_o));

  // Consumer stalls at random; words are taken where valid meets ready
  always @(posedge clk_i) begin
    if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) got_q.push_back(rx_data_o);
    if (overrun_o === 1'b1) ovr_n++;
    rx_ready_i <= drain ? 1'($urandom) : 1'b0;
  end

  // ==========================================================
  // Checking and closing
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk8

  task automatic chk1(input string n, input logic e, input logic g);
    chk8(n, {7'h0, e}, {7'h0, g});
  endtask : chk1

  task automatic stop_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  // Bypass output lags the input by one stage that captured zero
  function automatic logic [7:0] exp_byp(input logic [7:0] din);
    return {din[6:0], 1'b0};
  endfunction : exp_byp

  // ==========================================================
  // Scan helpers, each scan starts and ends in Run-Test/Idle
  task automatic st(input logic t);
    logic o;
    logic oe;
    ctl.step(t, 1'b0, o, oe);
  endtask : st

  task automatic scan(input logic ir, input logic [7:0] din, output logic [7:0] dout,
                      input int brk = 8);
    logic o;
    logic oe;
    int   i;
    int   j;
    st(1'b1);
    if (ir) st(1'b1);
    st(1'b0);
    st(1'b0);
    // Eight bits LSB first, mode raised with the last one; brk below 8 pauses once
    for (i = 0; i < 8; i++) begin
      ctl.step(i == 7 || i == brk - 1, din[i], o, oe);
      dout[i] = o;
      chk1("tdo enable in shift", 1'b0, oe);
      // Exit1, Pause, Exit2, then back into the shift state
      if (i < 7 && i == brk - 1) begin
        for (j = 0; j < 3; j++) begin
          ctl.step(j == 1, 1'b0, o, oe);
          chk1("tdo enable in pause", 1'b1, oe);
        end
      end
    end
    // Let the falling edge that floats the output settle before looking
    #1;
    chk1("tdo enable in exit1", 1'b1, tdo_oe_n_o);
    st(1'b1);
    st(1'b0);
  endtask : scan

  // Watchdog, far beyond the few microseconds the sequence needs
  initial begin
    #60000;
    fail_count++;
    stop_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] u, d, p, q;
    int         k;
    void'($urandom(16));
    // Test clock must run while reset is low
    fork
      repeat (4) @(posedge clk_i);
      repeat (5) st(1'b1);
    join
    chk1("tdo enable in reset", 1'b1, tdo_oe_n_o);
    chk8("instruction in reset", 8'hff, instr_o);
    chk8("test out in reset", 8'h00, test_out_o);
    @(posedge clk_i);
    resetn_i <= 1'b1;
    st(1'b1);
    st(1'b1);
    st(1'b0);
    // Register scans with random words, the highest user opcode first
    for (k = 0; k < 4; k++) begin
      u = (k == 0) ? 8'hfe : 8'($urandom);
      if (u == 8'hff) u = 8'h00;
      d = $urandom;
      p = $urandom;
      @(posedge clk_i);
      pin_in_i <= p;
      // The first three rounds pause the shift once, after five to seven bits; the last round does not pause
      scan(1'b1, u, q, k + 5);
      chk8("ir capture", 8'h81, q);
      chk8("instruction", u, instr_o);
      scan(1'b0, d, q, k + 5);
      chk8("dr capture", p, q);
      chk8("test out", d, test_out_o);
      exp_q.push_back(d);
      scan(1'b1, 8'hff, q);
      chk8("bypass instruction", 8'hff, instr_o);
      scan(1'b0, ~d, q);
      chk8("bypass out", exp_byp(~d), q);
      chk8("test out kept", d, test_out_o);
    end
    // Fill buffer and holder while the consumer stalls, one update is lost
    repeat (60) @(posedge clk_i);
    drain <= 1'b0;
    scan(1'b1, 8'h3c, q);
    for (k = 0; k < 18; k++) begin
      d = $urandom;
      scan(1'b0, d, q);
      if (k < 17) exp_q.push_back(d);
    end
    repeat (20) @(posedge clk_i);
    chk8("overrun pulses", 8'h01, 8'(ovr_n));
    drain <= 1'b1;
    // Five high mode bits from the first bit of a data shift return to reset
    scan(1'b1, 8'h5a, q);
    st(1'b1);
    st(1'b0);
    st(1'b0);
    repeat (5) st(1'b1);
    // The walk passes Update-DR: pins captured, then one zero shifted in
    exp_q.push_back({1'b0, p[7:1]});
    // The last falling edge loads the reset instruction; let it settle
    #1;
    chk8("test out after reset walk", {1'b0, p[7:1]}, test_out_o);
    chk8("instruction after reset walk", 8'hff, instr_o);
    chk1("tdo enable after reset walk", 1'b1, tdo_oe_n_o);
    repeat (200) @(posedge clk_i);
    chk8("word count", 8'(exp_q.size()), 8'(got_q.size()));
    foreach (exp_q[i]) if (i < got_q.size()) chk8("word", exp_q[i], got_q[i]);
    stop_test();
  end
endmodule : tst_top_test
`default_nettype wire
